// >>> rtl/aaie_exec.sv
/*
  Executor for AND (literal/Wn, Wb/short literal, Wb/Ws) and ASR of a file
  register. Holds the sixteen working registers and the flags word.
  Assumes memory reads answer combinationally with memAck; byte reads
  return the addressed byte in bits 7:0, byte writes touch one byte only.
*/
`timescale 1ns/1ps
`default_nettype none
module aaie_exec (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic instrValid,
  input wire logic [23:0] instrWord,
  output logic instrReady,
  output aaie_pkg::aaie_rd_t memRd,
  input wire logic [15:0] memRdData,
  output aaie_pkg::aaie_wr_t memWr,
  input wire logic memAck,
  output logic [15:0] flagsWord,
  output logic execDone,
  output logic illegalOp
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  aaie_pkg::aaie_state_t st_q, st_d;
  logic opLit10, opLit5, opRegReg, opAsr, isAnd, known, byteOp, needMem, commit;
  logic destIsReg, resZero, resNeg, asrCarry;
  aaie_pkg::aaie_mode_t srcMode, dstMode;
  logic [3:0] baseIdx, srcIdx, dstIdx;
  logic [15:0] step, srcPtr, dstPtr, srcAddr, dstAddr, opA, opB, srcVal, res, dstOld;

  always_comb begin
    opLit10 = instrWord[23:16] == aaie_pkg::OP_TEN_BIT_IMMEDIATE && !instrWord[15];
    opLit5 = instrWord[23:19] == aaie_pkg::OP_WBOP
             && instrWord[6:5] == aaie_pkg::FIVE_BIT_IMMEDIATE_TAG;
    opRegReg = instrWord[23:19] == aaie_pkg::OP_WBOP
               && instrWord[6:5] != aaie_pkg::FIVE_BIT_IMMEDIATE_TAG;
    opAsr = instrWord[23:16] == aaie_pkg::OP_ASRF && instrWord[15];
    isAnd = opLit10 || opLit5 || opRegReg;
    byteOp = instrWord[14];
    step = byteOp ? aaie_pkg::STEP_BYTE : aaie_pkg::STEP_WORD;
    srcMode = aaie_pkg::aaie_mode_t'(instrWord[6:4]);
    dstMode = aaie_pkg::aaie_mode_t'(instrWord[13:11]);
    baseIdx = instrWord[18:15];
    srcIdx = instrWord[3:0];
    // Literal form keeps its register in the low nibble
    dstIdx = opLit10 ? instrWord[3:0] : instrWord[10:7];
    if (opAsr) begin
      dstIdx = aaie_pkg::DEFAULT_DEFAULT_WORKING_REG;
    end
    // Reserved mode codes are refused rather than guessed
    known = opLit10 || opAsr
            || ((opLit5 || opRegReg) && instrWord[13:11] <= 3'h5
                && (opLit5 || instrWord[6:4] <= 3'h5));
    destIsReg = opLit10 || (opAsr && !instrWord[13])
                || ((opLit5 || opRegReg) && dstMode == aaie_pkg::AM_DIRECT);
  end

  // ----------------------------------------
  // Effective addresses
  // ----------------------------------------
  always_comb begin
    srcPtr = st_q.default_working_reg[srcIdx];
    dstPtr = st_q.default_working_reg[instrWord[10:7]];
    unique case (srcMode)
      aaie_pkg::AM_PREDEC: srcAddr = srcPtr - step;
      aaie_pkg::AM_PREINC: srcAddr = srcPtr + step;
      default: srcAddr = srcPtr;
    endcase
    unique case (dstMode)
      aaie_pkg::AM_PREDEC: dstAddr = dstPtr - step;
      aaie_pkg::AM_PREINC: dstAddr = dstPtr + step;
      default: dstAddr = dstPtr;
    endcase
  end

  // ----------------------------------------
  // Memory ports
  // ----------------------------------------
  always_comb begin
    memRd = '0;
    memWr = '0;
    memRd.byteMode = byteOp;
    memWr.byteMode = byteOp;
    memWr.data = res;
    if (opAsr) begin
      memRd.en = instrValid && clkEn;
      memRd.addr = {3'h0, instrWord[12:0]};
      memWr.en = instrValid && clkEn && instrWord[13];
      memWr.addr = {3'h0, instrWord[12:0]};
    end else if (known && (opLit5 || opRegReg)) begin
      memRd.en = instrValid && clkEn && opRegReg && srcMode != aaie_pkg::AM_DIRECT;
      memRd.addr = srcAddr;
      memWr.en = instrValid && clkEn && dstMode != aaie_pkg::AM_DIRECT;
      memWr.addr = dstAddr;
    end
    // Writes only land on the committing cycle
    memWr.en = memWr.en && commit;
  end

  // Memory accesses may take extra cycles; the instruction waits for memAck
  assign needMem = memRd.en || (instrValid && clkEn && !destIsReg && known);
  assign instrReady = clkEn && (!needMem || memAck);
  assign commit = instrValid && instrReady;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  always_comb begin
    srcVal = (srcMode == aaie_pkg::AM_DIRECT) ? st_q.default_working_reg[srcIdx] : memRdData;
    opA = st_q.default_working_reg[opLit10 ? instrWord[3:0] : baseIdx];
    if (opLit10) begin
      // Byte form uses only the low eight immediate bits
      opB = byteOp ? {8'h00, instrWord[11:4]} : {6'h00, instrWord[13:4]};
    end else if (opLit5) begin
      opB = {11'h000, instrWord[4:0]};
    end else begin
      opB = srcVal;
    end
    if (opAsr) begin
      res = byteOp ? {8'h00, memRdData[7], memRdData[7:1]}
                   : {memRdData[15], memRdData[15:1]};
    end else begin
      res = opA & opB;
    end
    asrCarry = memRdData[0];
    resNeg = byteOp ? res[7] : res[15];
    resZero = byteOp ? (res[7:0] == 8'h00) : (res == 16'h0000);
    dstOld = st_q.default_working_reg[dstIdx];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    st_d.badOp = 1'b0;
    if (commit && !known) begin
      st_d.badOp = 1'b1;
    end else if (commit) begin
      st_d.done = 1'b1;
      if (opLit5 || opRegReg) begin
        if (opRegReg) begin
          unique case (srcMode)
            aaie_pkg::AM_POSTDEC, aaie_pkg::AM_PREDEC: st_d.default_working_reg[srcIdx] = srcPtr - step;
            aaie_pkg::AM_POSTINC, aaie_pkg::AM_PREINC: st_d.default_working_reg[srcIdx] = srcPtr + step;
            default: st_d.default_working_reg[srcIdx] = srcPtr;
          endcase
        end
        unique case (dstMode)
          aaie_pkg::AM_POSTDEC, aaie_pkg::AM_PREDEC:
            st_d.default_working_reg[instrWord[10:7]] = dstPtr - step;
          aaie_pkg::AM_POSTINC, aaie_pkg::AM_PREINC:
            st_d.default_working_reg[instrWord[10:7]] = dstPtr + step;
          default: st_d.default_working_reg[instrWord[10:7]] = st_d.default_working_reg[instrWord[10:7]];
        endcase
      end
      if (destIsReg) begin
        st_d.default_working_reg[dstIdx] = byteOp ? {dstOld[15:8], res[7:0]} : res;
      end
      st_d.flags[aaie_pkg::FLAG_N] = resNeg;
      st_d.flags[aaie_pkg::FLAG_Z] = resZero;
      if (opAsr) begin
        st_d.flags[aaie_pkg::FLAG_C] = asrCarry;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q.default_working_reg <= {16{aaie_pkg::DEFAULT_WORKING_REG_RST}};
      st_q.flags <= aaie_pkg::FLAGS_RST;
      st_q.done <= 1'b0;
      st_q.badOp <= 1'b0;
    end else if (clkEn) begin
      st_q <= st_d;
    end
  end

  assign flagsWord = st_q.flags;
  assign execDone = st_q.done;
  assign illegalOp = st_q.badOp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  litDest_a: assert property (commit && opLit10 && !byteOp |=>
    st_q.default_working_reg[$past(srcIdx)] == $past(res)) else $error("literal AND result wrong");
  carryKeep_a: assert property (commit && isAnd |=>
    $stable(st_q.flags[aaie_pkg::FLAG_C])) else $error("AND touched carry");
  otherFlags_a: assert property (commit |=>
    st_q.flags[15:4] == $past(st_q.flags[15:4]) && st_q.flags[2] == $past(st_q.flags[2]))
    else $error("unrelated flag changed");
  asrCarry_a: assert property (commit && opAsr |=>
    st_q.flags[aaie_pkg::FLAG_C] == $past(memRdData[0])) else $error("shift carry wrong");
  asrWreg_a: assert property (commit && opAsr && !instrWord[13] |=>
    st_q.default_working_reg[0][7:0] == $past(res[7:0])) else $error("shift not in W0");
  asrFile_a: assert property (commit && opAsr && instrWord[13] |->
    memWr.en && memWr.addr == {3'h0, instrWord[12:0]}) else $error("shift not to file");
  byteKeep_a: assert property (commit && byteOp && destIsReg |=>
    st_q.default_working_reg[$past(dstIdx)][15:8] == $past(dstOld[15:8])) else $error("upper byte lost");
  zeroFlag_a: assert property (commit && known |=>
    st_q.flags[aaie_pkg::FLAG_Z] == $past(resZero)) else $error("zero flag wrong");
  stallHold_a: assert property (clkEn && instrValid && needMem && !memAck |=>
    $stable(st_q.default_working_reg) && !execDone) else $error("stall lost state");
  // A frozen cycle holds the pulse, so the second step allows for it
  doneNext_a: assert property (commit && known |=> execDone ##1
    (execDone == ($past(commit && known) || $past(!clkEn && execDone))))
    else $error("done pulse wrong");

  // ----------------------------------------
  // Operand and flag checks
  // ----------------------------------------
  // Expected values rebuilt from operands, except the N flag, which is taken from the datapath result
  negFlag_a: assert property (commit && known |=>
    st_q.flags[aaie_pkg::FLAG_N] == $past(byteOp ? res[7] : res[15])) else $error("neg flag wrong");
  litWord_a: assert property (commit && opLit10 && !byteOp |=>
    st_q.default_working_reg[$past(instrWord[3:0])] == $past(st_q.default_working_reg[instrWord[3:0]] & {6'h00, instrWord[13:4]}))
    else $error("word literal AND wrong");
  litByte_a: assert property (commit && opLit10 && byteOp |=>
    st_q.default_working_reg[$past(instrWord[3:0])][7:0] == $past(st_q.default_working_reg[instrWord[3:0]][7:0] & instrWord[11:4]))
    else $error("byte literal AND wrong");
  litNoMem_a: assert property (commit && opLit10 |->
    !memRd.en && !memWr.en) else $error("literal form touched memory");
  lit5Dest_a: assert property (commit && opLit5 && known && dstMode == aaie_pkg::AM_DIRECT && !byteOp |=>
    st_q.default_working_reg[$past(instrWord[10:7])] == $past(st_q.default_working_reg[baseIdx] & {11'h000, instrWord[4:0]}))
    else $error("short literal AND wrong");
  regDest_a: assert property (commit && opRegReg && known && srcMode == aaie_pkg::AM_DIRECT
    && dstMode == aaie_pkg::AM_DIRECT && !byteOp |=> st_q.default_working_reg[$past(instrWord[10:7])]
    == $past(st_q.default_working_reg[baseIdx] & st_q.default_working_reg[srcIdx])) else $error("register AND wrong");
  illegalKeep_a: assert property (commit && !known |=>
    $stable(st_q.default_working_reg) && $stable(st_q.flags) && illegalOp) else $error("illegal word had effect");
  illegalNoWr_a: assert property (commit && !known |->
    !memWr.en) else $error("illegal word wrote memory");
  pulseExcl_a: assert property (!(execDone && illegalOp))
    else $error("both pulses at once");

  // ----------------------------------------
  // Pointer, shift and stall checks
  // ----------------------------------------
  postInc_a: assert property (commit && opRegReg && known && srcMode == aaie_pkg::AM_POSTINC
    && instrWord[10:7] != srcIdx |=> st_q.default_working_reg[$past(srcIdx)] == $past(st_q.default_working_reg[srcIdx])
    + ($past(byteOp) ? aaie_pkg::STEP_BYTE : aaie_pkg::STEP_WORD)) else $error("post-inc step wrong");
  preDecAddr_a: assert property (commit && opRegReg && known && srcMode == aaie_pkg::AM_PREDEC |->
    memRd.en && memRd.addr == st_q.default_working_reg[srcIdx] - (byteOp ? aaie_pkg::STEP_BYTE : aaie_pkg::STEP_WORD))
    else $error("pre-dec address wrong");
  ptrDec_a: assert property (commit && opLit5 && known && dstMode == aaie_pkg::AM_POSTDEC |=>
    st_q.default_working_reg[$past(instrWord[10:7])] == $past(st_q.default_working_reg[instrWord[10:7]])
    - ($past(byteOp) ? aaie_pkg::STEP_BYTE : aaie_pkg::STEP_WORD)) else $error("post-dec step wrong");
  postIncAddr_a: assert property (commit && opLit5 && known && dstMode == aaie_pkg::AM_POSTINC |->
    memWr.en && memWr.addr == st_q.default_working_reg[instrWord[10:7]])
    else $error("post-inc address wrong");
  asrRead_a: assert property (clkEn && instrValid && opAsr |->
    memRd.en && memRd.addr == {3'h0, instrWord[12:0]})
    else $error("shift read address wrong");
  asrSign_a: assert property (commit && opAsr && !byteOp && !instrWord[13] |=>
    st_q.default_working_reg[0][15] == $past(memRdData[15]) && st_q.default_working_reg[0][14] == $past(memRdData[15]))
    else $error("word shift sign lost");
  asrByteSign_a: assert property (commit && opAsr && byteOp && !instrWord[13] |=>
    st_q.default_working_reg[0][7:6] == {2{$past(memRdData[7])}}) else $error("byte shift sign lost");
  asrByteWr_a: assert property (commit && opAsr && instrWord[13] && byteOp |->
    memWr.byteMode && memWr.data[7:6] == {2{memRdData[7]}})
    else $error("byte shift write wrong");
  readyFree_a: assert property (clkEn && !needMem |-> instrReady)
    else $error("stall without memory");
  frozen_a: assert property (!clkEn |=> $stable(st_q))
    else $error("state moved while frozen");

  litCov_c: cover property (commit && opLit10 && byteOp);
  lit5Cov_c: cover property (commit && opLit5 && dstMode == aaie_pkg::AM_POSTINC);
  regCov_c: cover property (commit && opRegReg && srcMode == aaie_pkg::AM_PREDEC);
  asrCov_c: cover property (commit && opAsr && instrWord[13]);
  illegCov_c: cover property (commit && !known);
endmodule // aaie_exec
`default_nettype wire

// >>> rtl/aaie_pkg.sv
/*
  Shared constants and types for the AND / arithmetic-shift-right executor.
  Assumes a byte-addressed data memory and a 24-bit instruction word.
*/
package aaie_pkg;
  // ----------------------------------------
  // Flag positions and reset values
  // ----------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 3;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] DEFAULT_WORKING_REG_RST = 16'h0000;
  localparam logic [3:0] DEFAULT_DEFAULT_WORKING_REG = 4'h0;
  localparam int EXEC_CYCLES = 1;

  // ----------------------------------------
  // Opcode patterns
  // ----------------------------------------
  localparam logic [7:0] OP_TEN_BIT_IMMEDIATE = 8'hb2;
  localparam logic [4:0] OP_WBOP = 5'h0c;
  localparam logic [7:0] OP_ASRF = 8'hd5;
  localparam logic [1:0] FIVE_BIT_IMMEDIATE_TAG = 2'h3;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;

  typedef enum logic [2:0] {
    AM_DIRECT = 3'h0,
    AM_IND = 3'h1,
    AM_POSTDEC = 3'h2,
    AM_POSTINC = 3'h3,
    AM_PREDEC = 3'h4,
    AM_PREINC = 3'h5
  } aaie_mode_t;

  typedef struct packed {
    logic en;
    logic byteMode;
    logic [15:0] addr;
  } aaie_rd_t;

  typedef struct packed {
    logic en;
    logic byteMode;
    logic [15:0] addr;
    logic [15:0] data;
  } aaie_wr_t;

  typedef struct packed {
    logic [15:0][15:0] default_working_reg;
    logic [15:0] flags;
    logic done;
    logic badOp;
  } aaie_state_t;
endpackage

// >>> verif/aaie_mem_model.sv
/*
  Data memory facing the executor: byte array, same-cycle reads, random stalls.
  Assumes requests are held until memAck is seen at a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module aaie_mem_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic runEn,
  input wire aaie_pkg::aaie_rd_t memRd,
  input wire aaie_pkg::aaie_wr_t memWr,
  output logic [15:0] memRdData,
  output logic memAck
);
  // ----------------------------------------
  // Storage and answers
  // ----------------------------------------
  logic [7:0] mem [0:65535];
  logic [15:0] rdWord;
  logic [15:0] lastQ;
  int ackSeed = 7;
  initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
  assign rdWord = memRd.byteMode ? {8'h00, mem[memRd.addr]} :
    {mem[memRd.addr + 16'h0001], mem[memRd.addr]};
  // Idle bus shows inverted data, so a stale read cannot pass
  assign memRdData = memRd.en ? rdWord : ~lastQ;
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b1;
      lastQ <= 16'h0000;
    end else begin
      memAck <= slow ? ({$random(ackSeed)} % 3 != 0) : 1'b1;
      if (memRd.en) lastQ <= rdWord;
      if (memWr.en && memAck && runEn) begin
        mem[memWr.addr] <= memWr.data[7:0];
        if (!memWr.byteMode) mem[memWr.addr + 16'h0001] <= memWr.data[15:8];
      end
    end
  end
endmodule // aaie_mem_model
`default_nettype wire

// >>> verif/tb.sv
/*
  Self-checking bench for the AND / shift executor.
  Assumes a 200 MHz clock; W0 is observed by storing it through [W1].
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin errTotal++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
  logic mclk, rst_n, instrValid, slow, instrReady, execDone, illegalOp, memAck, b;
  logic clkEn = 1'b1;
  logic [23:0] instrWord;
  logic [15:0] memRdData, flagsWord, w0, flg, v, r, k, f;
  logic [3:0] ri;
  aaie_pkg::aaie_rd_t memRd;
  aaie_pkg::aaie_wr_t memWr;
  int errTotal = 0, checkCount = 0, seed = 1101;
  aaie_exec i_aaie_exec (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
    .instrValid(instrValid), .instrWord(instrWord), .instrReady(instrReady),
    .memRd(memRd), .memRdData(memRdData), .memWr(memWr), .memAck(memAck),
    .flagsWord(flagsWord), .execDone(execDone), .illegalOp(illegalOp));
  aaie_mem_model i_aaie_mem_model (.mclk(mclk), .rst_n(rst_n), .slow(slow),
    .runEn(clkEn), .memRd(memRd), .memWr(memWr), .memRdData(memRdData), .memAck(memAck));
  // ----------------------------------------
  // Expectations and bus cycle
  // ----------------------------------------
  function automatic logic [15:0] nzc(input logic [15:0] x, input logic bm, input logic c);
    return {12'h000, bm ? x[7] : x[15], 1'b0, bm ? x[7:0] == 8'h00 : x == 16'h0000, c};
  endfunction
  function automatic logic [15:0] peek(input logic [15:0] a);
    return {i_aaie_mem_model.mem[a + 16'h0001], i_aaie_mem_model.mem[a]};
  endfunction
  task automatic issue(input logic [23:0] w, input logic bad);
    int n;
    n = 0;
    instrValid <= 1'b1;
    instrWord <= w;
    do begin
      @(negedge mclk);
      n++;
    end while (instrReady !== 1'b1 && n < 64);
    @(posedge mclk);
    instrValid <= 1'b0;
    @(negedge mclk);
    if (!slow) `CHK("cycles", 1, n)
    `CHK("pulses", {~bad, bad}, {execDone, illegalOp})
    `CHK("flags", flg, flagsWord)
    @(posedge mclk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checkCount, errTotal);
    if (errTotal == 0 && checkCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Stalls and clock-enable gaps only in the slow half
  always @(posedge mclk) clkEn <= slow ? 1'($random(seed)) | 1'($random(seed)) : 1'b1;
  initial begin
    repeat (50000) @(posedge mclk);
    errTotal++;
    close_out();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    instrValid = 1'b0;
    instrWord = 24'h000000;
    slow = 1'b0;
    w0 = 16'h0000;
    flg = 16'h0000;
    repeat (20) @(posedge mclk);
    `CHK("reset", {aaie_pkg::FLAGS_RST, 2'b00}, {flagsWord, execDone, illegalOp})
    rst_n <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      slow <= (i >= 30);
      b = (i == 1) ? 1'b1 : (i == 0) ? 1'b0 : 1'($random(seed));
      v = (i == 0) ? 16'h8009 : (i == 1) ? 16'h0823 : 16'($random(seed));
      f = {7'h01, 8'($random(seed)), 1'b0};
      i_aaie_mem_model.mem[f] = v[7:0];
      i_aaie_mem_model.mem[f + 16'h0001] = v[15:8];
      r = b ? {v[15:8], v[7], v[7:1]} : {v[15], v[15:1]};
      w0 = b ? {w0[15:8], r[7:0]} : r;
      flg = nzc(r, b, v[0]);
      issue({8'hd5, 1'b1, b, 1'b0, f[12:0]}, 1'b0);
      issue({8'hd5, 1'b1, b, 1'b1, f[12:0]}, 1'b0);
      `CHK("shift", r, peek(f))
      k = 16'($random(seed)) & (b ? 16'h00ff : 16'h03ff);
      ri = (i % 4 == 3) ? {3'($random(seed)), 1'b1} : 4'h0;
      if (ri == 4'h0) w0 = b ? {w0[15:8], w0[7:0] & k[7:0]} : w0 & k;
      flg = nzc(ri == 4'h0 ? w0 : 16'h0000, b, flg[0]);
      issue({8'hb2, 1'b0, b, k[9:0], ri}, 1'b0);
      flg = nzc(w0, 1'b0, flg[0]);
      issue({5'h0c, 4'h0, 1'b0, 3'h1, 4'h1, 3'h0, 4'h0}, 1'b0);
      `CHK("store", w0, peek(16'h0000))
      k = 16'($random(seed)) & 16'h001f;
      r = b ? {w0[15:8], w0[7:0] & k[7:0]} : w0 & k;
      flg = nzc(r, b, flg[0]);
      issue({5'h0c, 4'h0, b, 3'h1, 4'h1, 2'h3, k[4:0]}, 1'b0);
      `CHK("short", r, peek(16'h0000))
      issue({5'h0c, 4'h0, 1'b0, 3'h6, 4'h1, 3'h0, 4'h0}, 1'b1);
      `CHK("refused", r, peek(16'h0000))
      $display("test %0d done", i);
    end
    // Post-increment source must step W2 by two in word mode
    i_aaie_mem_model.mem[2] = 8'h3c;
    i_aaie_mem_model.mem[3] = 8'h5a;
    r = w0 & peek(16'h0000);
    flg = nzc(r, 1'b0, flg[0]);
    issue({5'h0c, 4'h0, 1'b0, 3'h1, 4'h1, 3'h3, 4'h2}, 1'b0);
    `CHK("postinc", r, peek(16'h0000))
    r = w0 & 16'h5a3c;
    flg = nzc(r, 1'b0, flg[0]);
    issue({5'h0c, 4'h0, 1'b0, 3'h1, 4'h1, 3'h1, 4'h2}, 1'b0);
    `CHK("stepped", r, peek(16'h0000))
    $display("test pointer done");
    close_out();
  end
endmodule // tb
`default_nettype wire
